//--- include/scss_regs.svh
`ifndef SCSS_REGS_SVH
`define SCSS_REGS_SVH

// Core clock rate
`define SCSS_CLK_MHZ 100
// Stabilization after reset, supply recovery or power-down exit
`define SCSS_STAB_MS 10
`define SCSS_STAB_CYC (`SCSS_STAB_MS * 1000 * `SCSS_CLK_MHZ)
// Activation and deactivation step interval
`define SCSS_STEP_US 20
`define SCSS_STEP_CYC (`SCSS_STEP_US * `SCSS_CLK_MHZ)
// Card supply discharge interval
`define SCSS_DISCH_US 40
`define SCSS_DISCH_CYC (`SCSS_DISCH_US * `SCSS_CLK_MHZ)
// Card clock cycles before card reset may rise
`define SCSS_RST_HOLD_CLKS 42000
// Widths
`define SCSS_TMR_W 20
`define SCSS_CNT_W 16
`define SCSS_LINES 3
`define SCSS_PINS 8
// Synchronised pin positions
`define SCSS_P_ACT_N 0
`define SCSS_P_POWER_DOWN_REQUEST 1
`define SCSS_P_HRST 2
`define SCSS_P_CARD_PRESENCE_DETECT 3
`define SCSS_P_VDDF 4
`define SCSS_P_VCCF 5
`define SCSS_P_OVC 6
`define SCSS_P_OVT 7

`endif

//--- include/scss_pkg.sv
package scss_pkg;

  typedef enum logic [3:0] {
    ST_LOWPWR = 4'h0,
    ST_STAB = 4'h1,
    ST_IDLE = 4'h2,
    ST_ACT_SUPPLY = 4'h3,
    ST_ACT_IO = 4'h4,
    ST_ACT_CLK = 4'h5,
    ST_ACT_RST = 4'h6,
    ST_SESSION = 4'h7,
    ST_DEA_RST = 4'h8,
    ST_DEA_CLK = 4'h9,
    ST_DEA_IO = 4'ha,
    ST_DEA_SUPPLY = 4'hb,
    ST_DISCHARGE = 4'hc
  } scss_state_type;

  typedef enum logic [1:0] {
    IO_NEUTRAL = 2'h0,
    IO_HOST_IN = 2'h1,
    IO_CARD_IN = 2'h2
  } scss_io_state_type;

endpackage

//--- include/scss_io_if.sv
`timescale 1ns/1ps
// One host/card line pair and its reception enable
interface scss_io_if;
  logic rx_en;
  logic host_in;
  logic card_in;
  logic host_o;
  logic host_oe_n;
  logic card_o;
  logic card_oe_n;
  modport arb (input rx_en, host_in, card_in,
               output host_o, host_oe_n, card_o, card_oe_n);
  modport ctl (output rx_en, host_in, card_in,
               input host_o, host_oe_n, card_o, card_oe_n);
endinterface

//--- src/scss_io_arb.sv
`timescale 1ns/1ps
module scss_io_arb (
  input logic clk_i,       // Core clock
  input logic rstn_i,      // Synchronous reset, active low
  scss_io_if.arb io        // Line pair
);

  scss_pkg::scss_io_state_type st;
  logic host_prev;
  logic card_prev;

  // Previous line levels for edge detection
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      host_prev <= 1'b1;
      card_prev <= 1'b1;
    end else begin
      host_prev <= io.host_in;
      card_prev <= io.card_in;
    end
  end

  // First falling side becomes input; its rise frees both
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !io.rx_en) begin
      st <= scss_pkg::IO_NEUTRAL;
    end else begin
      unique case (st)
        scss_pkg::IO_NEUTRAL: begin
          if (host_prev && !io.host_in) begin
            st <= scss_pkg::IO_HOST_IN;
          end else if (card_prev && !io.card_in) begin
            st <= scss_pkg::IO_CARD_IN;
          end
        end
        scss_pkg::IO_HOST_IN: begin
          if (!host_prev && io.host_in) begin
            st <= scss_pkg::IO_NEUTRAL;
          end
        end
        scss_pkg::IO_CARD_IN: begin
          if (!card_prev && io.card_in) begin
            st <= scss_pkg::IO_NEUTRAL;
          end
        end
        default: st <= scss_pkg::IO_NEUTRAL;
      endcase
    end
  end

  // Registered drivers; card side held low until reception
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      io.host_o <= 1'b1;
      io.host_oe_n <= 1'b1;
      io.card_o <= 1'b0;
      io.card_oe_n <= 1'b0;
    end else begin
      io.host_o <= 1'b1;
      io.host_oe_n <= 1'b1;
      io.card_o <= io.rx_en;
      io.card_oe_n <= io.rx_en;
      if (io.rx_en && st == scss_pkg::IO_HOST_IN) begin
        io.card_o <= io.host_in;
        io.card_oe_n <= 1'b0;
      end else if (io.rx_en && st == scss_pkg::IO_CARD_IN) begin
        io.host_o <= io.card_in;
        io.host_oe_n <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_card_held_low: assert property (!io.rx_en |=>
    !io.card_oe_n && !io.card_o)
    else $error("card line not held low outside reception");
  a_input_release: assert property (st == scss_pkg::IO_HOST_IN &&
    !host_prev && io.host_in && io.rx_en |=> ##1 io.card_oe_n)
    else $error("card line still driven after host rise");
  a_host_follow: assert property (io.rx_en &&
    st == scss_pkg::IO_NEUTRAL && host_prev && !io.host_in ##1 io.rx_en
    |=> !io.card_oe_n && !io.card_o)
    else $error("card line does not follow host fall");
  c_host_input: cover property (st == scss_pkg::IO_HOST_IN);

endmodule

//--- src/scss_top.sv
`timescale 1ns/1ps
`include "scss_regs.svh"

module scss_top #(
  parameter int unsigned STAB_CYC = `SCSS_STAB_CYC,       // Stabilize time
  parameter int unsigned RST_HOLD = `SCSS_RST_HOLD_CLKS   // Card clocks
) (
  input logic MCLK_I,                      // Core clock, 100 MHz
  input logic RSTN_I,                      // Logic supply monitor reset
  input logic ACTIVATION_REQUEST_N_I,      // Host session request, low
  input logic POWER_DOWN_REQUEST_I,        // Host low power request
  input logic HOST_RESET_IN_I,             // Host card reset control
  input logic CARD_PRESENCE_DETECT_I,      // Card inserted
  input logic VDD_FAULT_I,                 // Logic supply below threshold
  input logic VCC_FAULT_I,                 // Card supply invalid
  input logic OVER_CURRENT_I,              // Card over-current
  input logic OVER_TEMP_I,                 // Die overheating
  input logic [2:0] HOST_IO_I,             // Host data, card_aux_line_1, card_aux_line_2 levels
  output logic [2:0] HOST_IO_O,            // Host line drive values
  output logic [2:0] HOST_IO_OE_N_O,       // Host line enables, low
  input logic [2:0] CARD_IO_I,             // Card data, card_aux_line_1, card_aux_line_2 levels
  output logic [2:0] CARD_IO_O,            // Card line drive values
  output logic [2:0] CARD_IO_OE_N_O,       // Card line enables, low
  output logic CARD_RESET_O,               // Card reset contact
  output logic CARD_CLOCK_O,               // Card clock contact
  output logic CARD_SUPPLY_EN_O,           // Card supply converter on
  output logic LOW_POWER_STATE_O,          // Device in low power
  output logic PRESENCE_FAULT_N_O          // Interrupt line, low = fault, no card or stabilizing
);

  localparam logic [`SCSS_TMR_W-1:0] STEP_CYC = `SCSS_TMR_W'(`SCSS_STEP_CYC);
  localparam logic [`SCSS_TMR_W-1:0] DISCH_CYC = `SCSS_TMR_W'(`SCSS_DISCH_CYC);
  localparam logic [`SCSS_TMR_W-1:0] STAB_LOAD = STAB_CYC[`SCSS_TMR_W-1:0];
  localparam logic [`SCSS_CNT_W-1:0] HOLD_CNT = RST_HOLD[`SCSS_CNT_W-1:0];

  scss_pkg::scss_state_type state;
  scss_pkg::scss_state_type next_state;
  logic [`SCSS_PINS-1:0] pin_meta;
  logic [`SCSS_PINS-1:0] pin_s;
  logic [2:0] hio_meta;
  logic [2:0] hio_s;
  logic [2:0] cio_meta;
  logic [2:0] cio_s;
  logic act_prev;
  logic act_fall;
  logic [`SCSS_TMR_W-1:0] timer;
  logic timer_done;
  logic hrst_mode;
  logic clk_run;
  logic [`SCSS_CNT_W-1:0] clk_cnt;
  logic rx_en;
  logic fault_flag;
  logic fault_evt;
  logic any_fault;

  // Active card session: from activation until deactivation starts
  function automatic logic in_session(scss_pkg::scss_state_type s);
    in_session = (s == scss_pkg::ST_ACT_SUPPLY) ||
                 (s == scss_pkg::ST_ACT_IO) ||
                 (s == scss_pkg::ST_ACT_CLK) ||
                 (s == scss_pkg::ST_ACT_RST) ||
                 (s == scss_pkg::ST_SESSION);
  endfunction

  // Deactivation steps, supply still being shut down
  function automatic logic in_deact(scss_pkg::scss_state_type s);
    in_deact = (s == scss_pkg::ST_DEA_RST) ||
               (s == scss_pkg::ST_DEA_CLK) ||
               (s == scss_pkg::ST_DEA_IO) ||
               (s == scss_pkg::ST_DEA_SUPPLY);
  endfunction

  // Two-stage synchronisers for every pin input
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      // Idle levels; request high so no false fall follows reset
      pin_meta <= 8'h01;
      pin_s <= 8'h01;
      hio_meta <= 3'h7;
      hio_s <= 3'h7;
      cio_meta <= 3'h0;
      cio_s <= 3'h0;
    end else begin
      pin_meta <= {OVER_TEMP_I, OVER_CURRENT_I, VCC_FAULT_I, VDD_FAULT_I,
                   CARD_PRESENCE_DETECT_I, HOST_RESET_IN_I,
                   POWER_DOWN_REQUEST_I, ACTIVATION_REQUEST_N_I};
      pin_s <= pin_meta;
      hio_meta <= HOST_IO_I;
      hio_s <= hio_meta;
      cio_meta <= CARD_IO_I;
      cio_s <= cio_meta;
    end
  end

  // Activation request is edge sensed
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      act_prev <= 1'b1;
    end else begin
      act_prev <= pin_s[`SCSS_P_ACT_N];
    end
  end

  assign act_fall = act_prev && !pin_s[`SCSS_P_ACT_N];

  // Faults only count inside a session; card supply still ramps in the
  // first interval, so its fault waits for the check at its end
  assign any_fault = pin_s[`SCSS_P_VDDF] || pin_s[`SCSS_P_OVC] ||
                     pin_s[`SCSS_P_OVT] || !pin_s[`SCSS_P_CARD_PRESENCE_DETECT] ||
                     (pin_s[`SCSS_P_VCCF] &&
                      state != scss_pkg::ST_ACT_SUPPLY);
  assign fault_evt = in_session(state) && any_fault;
  assign timer_done = (timer == '0);

  // Sequencer transitions
  always_comb begin
    next_state = state;
    unique case (state)
      scss_pkg::ST_LOWPWR: begin
        if (!pin_s[`SCSS_P_POWER_DOWN_REQUEST]) begin
          next_state = scss_pkg::ST_STAB;
        end
      end
      scss_pkg::ST_STAB: begin
        if (timer_done && !pin_s[`SCSS_P_VDDF]) begin
          next_state = scss_pkg::ST_IDLE;
        end
      end
      scss_pkg::ST_IDLE: begin
        if (pin_s[`SCSS_P_VDDF]) begin
          next_state = scss_pkg::ST_STAB;
        end else if (pin_s[`SCSS_P_POWER_DOWN_REQUEST] && pin_s[`SCSS_P_ACT_N]) begin
          next_state = scss_pkg::ST_LOWPWR;
        end else if (act_fall && pin_s[`SCSS_P_CARD_PRESENCE_DETECT]) begin
          next_state = scss_pkg::ST_ACT_SUPPLY;
        end
      end
      scss_pkg::ST_ACT_SUPPLY: begin
        if (timer_done && pin_s[`SCSS_P_VCCF]) begin
          next_state = scss_pkg::ST_DISCHARGE;
        end else if (fault_evt || pin_s[`SCSS_P_ACT_N]) begin
          next_state = scss_pkg::ST_DEA_RST;
        end else if (timer_done) begin
          next_state = scss_pkg::ST_ACT_IO;
        end
      end
      scss_pkg::ST_ACT_IO: begin
        if (fault_evt || pin_s[`SCSS_P_ACT_N]) begin
          next_state = scss_pkg::ST_DEA_RST;
        end else if (hrst_mode ? !pin_s[`SCSS_P_HRST] : timer_done) begin
          next_state = scss_pkg::ST_ACT_CLK;
        end
      end
      scss_pkg::ST_ACT_CLK, scss_pkg::ST_ACT_RST: begin
        if (fault_evt || pin_s[`SCSS_P_ACT_N]) begin
          next_state = scss_pkg::ST_DEA_RST;
        end else if (timer_done) begin
          next_state = (state == scss_pkg::ST_ACT_CLK) ?
                       scss_pkg::ST_ACT_RST : scss_pkg::ST_SESSION;
        end
      end
      scss_pkg::ST_SESSION: begin
        if (fault_evt || pin_s[`SCSS_P_ACT_N]) begin
          next_state = scss_pkg::ST_DEA_RST;
        end
      end
      scss_pkg::ST_DEA_RST: begin
        if (timer_done) next_state = scss_pkg::ST_DEA_CLK;
      end
      scss_pkg::ST_DEA_CLK: begin
        if (timer_done) next_state = scss_pkg::ST_DEA_IO;
      end
      scss_pkg::ST_DEA_IO: begin
        if (timer_done) next_state = scss_pkg::ST_DEA_SUPPLY;
      end
      scss_pkg::ST_DEA_SUPPLY: begin
        if (timer_done) next_state = scss_pkg::ST_DISCHARGE;
      end
      scss_pkg::ST_DISCHARGE: begin
        if (timer_done) next_state = scss_pkg::ST_IDLE;
      end
      default: next_state = scss_pkg::ST_STAB;
    endcase
  end

  // State register; reset is the logic supply monitor output
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      state <= scss_pkg::ST_STAB;
    end else begin
      state <= next_state;
    end
  end

  // Interval timer reloads on every state change
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      timer <= STAB_LOAD;
    end else if (next_state != state) begin
      unique case (next_state)
        scss_pkg::ST_STAB: timer <= STAB_LOAD;
        scss_pkg::ST_DISCHARGE: timer <= DISCH_CYC;
        default: timer <= STEP_CYC;
      endcase
    end else if (state == scss_pkg::ST_STAB && pin_s[`SCSS_P_VDDF]) begin
      timer <= STAB_LOAD;
    end else if (!timer_done) begin
      timer <= timer - 1'b1;
    end
  end

  // Host reset level captured when activation is accepted
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      hrst_mode <= 1'b0;
    end else if (state == scss_pkg::ST_IDLE &&
                 next_state == scss_pkg::ST_ACT_SUPPLY) begin
      hrst_mode <= pin_s[`SCSS_P_HRST];
    end
  end

  // Card supply: on from activation until the supply step
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      CARD_SUPPLY_EN_O <= 1'b0;
    end else begin
      CARD_SUPPLY_EN_O <= in_session(next_state) ||
                          (in_deact(next_state) &&
                           next_state != scss_pkg::ST_DISCHARGE);
    end
  end

  // Card clock runs from end of third interval to clock-off step
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      clk_run <= 1'b0;
    end else if (state == scss_pkg::ST_ACT_CLK &&
                 next_state == scss_pkg::ST_ACT_RST) begin
      clk_run <= 1'b1;
    end else if (state == scss_pkg::ST_DEA_CLK && timer_done) begin
      clk_run <= 1'b0;
    end else if (!in_session(state) && !in_deact(state)) begin
      clk_run <= 1'b0;
    end
  end

  // Fixed divide by two keeps duty cycle at half
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I || !clk_run) begin
      CARD_CLOCK_O <= 1'b0;
    end else begin
      CARD_CLOCK_O <= !CARD_CLOCK_O;
    end
  end

  // Card clock rising edges since start, saturating
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I || !clk_run) begin
      clk_cnt <= '0;
    end else if (!CARD_CLOCK_O && clk_cnt != HOLD_CNT) begin
      clk_cnt <= clk_cnt + 1'b1;
    end
  end

  // Card reset copies host reset in ST_SESSION once the hold count is met; held
  // through the first deactivation interval, dropped at its end
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      CARD_RESET_O <= 1'b0;
    end else if (state == scss_pkg::ST_DEA_RST) begin
      if (timer_done) CARD_RESET_O <= 1'b0;
    end else begin
      CARD_RESET_O <= (state == scss_pkg::ST_SESSION) &&
                      pin_s[`SCSS_P_HRST] && (clk_cnt == HOLD_CNT);
    end
  end

  // Reception state; in mode the host reset fall enables it, so a late one delays it
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      rx_en <= 1'b0;
    end else if (state == scss_pkg::ST_ACT_IO &&
                 next_state == scss_pkg::ST_ACT_CLK) begin
      rx_en <= 1'b1;
    end else if (state == scss_pkg::ST_DEA_IO && timer_done) begin
      rx_en <= 1'b0;
    end else if (!in_session(state) && !in_deact(state)) begin
      rx_en <= 1'b0;
    end
  end

  // Fault stays latched until the host releases the request
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      fault_flag <= 1'b0;
    end else if (fault_evt || (state == scss_pkg::ST_ACT_SUPPLY &&
                 timer_done && pin_s[`SCSS_P_VCCF])) begin
      fault_flag <= 1'b1;
    end else if (pin_s[`SCSS_P_ACT_N]) begin
      fault_flag <= 1'b0;
    end
  end

  // Interrupt line: low while stabilizing, fault inside session and while latched, presence otherwise
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      PRESENCE_FAULT_N_O <= 1'b0;
    end else if (fault_evt) begin
      PRESENCE_FAULT_N_O <= 1'b0;
    end else if (state == scss_pkg::ST_ACT_SUPPLY && timer_done &&
                 pin_s[`SCSS_P_VCCF]) begin
      PRESENCE_FAULT_N_O <= 1'b0;
    end else if (state == scss_pkg::ST_STAB) begin
      PRESENCE_FAULT_N_O <= 1'b0;
    end else if (fault_flag && !pin_s[`SCSS_P_ACT_N]) begin
      PRESENCE_FAULT_N_O <= 1'b0;
    end else if (in_session(state)) begin
      PRESENCE_FAULT_N_O <= 1'b1;
    end else begin
      PRESENCE_FAULT_N_O <= pin_s[`SCSS_P_CARD_PRESENCE_DETECT];
    end
  end

  // Low power flag; analog blocks are gated by it outside
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      LOW_POWER_STATE_O <= 1'b0;
    end else begin
      LOW_POWER_STATE_O <= (next_state == scss_pkg::ST_LOWPWR);
    end
  end

  // One arbiter per line pair: data, card_aux_line_1, card_aux_line_2
  scss_io_if io_pair [`SCSS_LINES] ();
  genvar g;
  generate
    for (g = 0; g < `SCSS_LINES; g++) begin : g_pair
      assign io_pair[g].rx_en = rx_en;
      assign io_pair[g].host_in = hio_s[g];
      assign io_pair[g].card_in = cio_s[g];
      assign HOST_IO_O[g] = io_pair[g].host_o;
      assign HOST_IO_OE_N_O[g] = io_pair[g].host_oe_n;
      assign CARD_IO_O[g] = io_pair[g].card_o;
      assign CARD_IO_OE_N_O[g] = io_pair[g].card_oe_n;
      scss_io_arb u_arb (
        .clk_i(MCLK_I),
        .rstn_i(RSTN_I),
        .io(io_pair[g])
      );
    end
  endgenerate

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  a_supply_fault_deact: assert property (in_session(state) &&
    state != scss_pkg::ST_ACT_SUPPLY &&
    (pin_s[`SCSS_P_VDDF] || pin_s[`SCSS_P_VCCF])
    |=> state == scss_pkg::ST_DEA_RST)
    else $error("supply fault did not start deactivation");
  a_lowpwr_entry: assert property ($rose(LOW_POWER_STATE_O) |->
    $past(pin_s[`SCSS_P_ACT_N]) && $past(state) == scss_pkg::ST_IDLE)
    else $error("low power entered during a session");
  a_lowpwr_quiet: assert property (state == scss_pkg::ST_LOWPWR |->
    !CARD_SUPPLY_EN_O && !clk_run && !rx_en)
    else $error("card interface active in low power");
  a_stab_ignore: assert property (state == scss_pkg::ST_STAB && act_fall
    |=> !in_session(state))
    else $error("activation accepted while stabilizing");
  a_vcc_check: assert property (state == scss_pkg::ST_ACT_SUPPLY &&
    timer_done && pin_s[`SCSS_P_VCCF]
    |=> !PRESENCE_FAULT_N_O ##1 !CARD_SUPPLY_EN_O)
    else $error("card supply failure not reported");
  a_rst_hold: assert property (CARD_RESET_O |->
    clk_cnt == HOLD_CNT && (state == scss_pkg::ST_SESSION ||
    state == scss_pkg::ST_DEA_RST))
    else $error("card reset high before hold count");
  a_fault_irq: assert property (fault_evt |=>
    !PRESENCE_FAULT_N_O && in_deact(state))
    else $error("session fault not flagged at once");
  a_idle_presence: assert property (state == scss_pkg::ST_IDLE &&
    pin_s[`SCSS_P_ACT_N] && !fault_evt
    |=> PRESENCE_FAULT_N_O == $past(pin_s[`SCSS_P_CARD_PRESENCE_DETECT]))
    else $error("interrupt line does not show presence");
  a_deact_order: assert property (state == scss_pkg::ST_DEA_CLK &&
    timer_done |=> !clk_run && !CARD_RESET_O && CARD_SUPPLY_EN_O)
    else $error("deactivation steps out of order");

  c_session: cover property (state == scss_pkg::ST_SESSION && CARD_RESET_O);
  c_fault_deact: cover property (fault_evt);
  c_lowpwr_exit: cover property (state == scss_pkg::ST_LOWPWR
    ##1 state == scss_pkg::ST_STAB);

endmodule

//--- test/scss_line_model.sv
`timescale 1ns/1ps
// Pull-up wire pairs; outside parties only ever pull a line low
module scss_line_model (
  input wire logic [2:0] h_o_i, // Host drive values
  input wire logic [2:0] h_oe_n_i, // Host enables, low
  input wire logic [2:0] c_o_i, // Card drive values
  input wire logic [2:0] c_oe_n_i, // Card enables, low
  input wire logic [2:0] h_pull_i, // Host party pulls low
  input wire logic [2:0] c_pull_i, // Card party pulls low
  output logic [2:0] h_lvl_o, // Host wire levels
  output logic [2:0] c_lvl_o // Card wire levels
);
  // Released wires read high; contention resolves low, as on a real wire
  assign h_lvl_o = (h_oe_n_i | h_o_i) & ~h_pull_i;
  assign c_lvl_o = (c_oe_n_i | c_o_i) & ~c_pull_i;
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int STAB = 50;
  logic clk = 1'h0, rn = 1'h0, an = 1'h1, pd = 1'h0, hr = 1'h0, pr = 1'h1;
  logic vd = 1'h0, vc = 1'h0, oc = 1'h0, ot = 1'h0, crst, cclk, csup, lp;
  logic irq, a;
  logic [2:0] hp = 3'h0, cp = 3'h0, hl, cl, ho, hoe, co, coe;
  int errors = 0, tests_run = 0, cycles = 0, i;
  integer seed = 32'hcbde85e6;
  scss_top #(.STAB_CYC(STAB), .RST_HOLD(20)) scss_top_inst (
    .MCLK_I(clk), .RSTN_I(rn), .ACTIVATION_REQUEST_N_I(an),
    .POWER_DOWN_REQUEST_I(pd), .HOST_RESET_IN_I(hr),
    .CARD_PRESENCE_DETECT_I(pr), .VDD_FAULT_I(vd), .VCC_FAULT_I(vc),
    .OVER_CURRENT_I(oc), .OVER_TEMP_I(ot), .HOST_IO_I(hl),
    .HOST_IO_O(ho), .HOST_IO_OE_N_O(hoe), .CARD_IO_I(cl),
    .CARD_IO_O(co), .CARD_IO_OE_N_O(coe), .CARD_RESET_O(crst),
    .CARD_CLOCK_O(cclk), .CARD_SUPPLY_EN_O(csup),
    .LOW_POWER_STATE_O(lp), .PRESENCE_FAULT_N_O(irq));
  scss_line_model scss_line_model_inst (.h_o_i(ho), .h_oe_n_i(hoe),
    .c_o_i(co), .c_oe_n_i(coe), .h_pull_i(hp), .c_pull_i(cp),
    .h_lvl_o(hl), .c_lvl_o(cl));
  // Core clock, 100 MHz
  always #5 clk = ~clk;
  // Hang guard, about 12800 cycles above the whole run
  always @(posedge clk) begin
    cycles++;
    if (cycles > 100000) begin
      errors++;
      end_of_test;
    end
  end
  // Inputs move only at falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [2:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Activation walk; hm is the host reset level at the request fall
  task automatic act(input logic hm);
    hr = hm;
    an = 1'h0;
    cyc(10);
    chk("supply", 3'h1, csup);
    cyc(4010);
    chk("card_oe_n", hm ? 3'h0 : 3'h7, coe);
    hr = 1'h0;
    cyc(10);
    chk("card_oe_n", 3'h7, coe);
    cyc(2010);
    a = cclk;
    cyc(1);
    chk("card_clock_run", 3'h1, a ^ cclk);
    hr = 1'h1;
    cyc(1900);
    chk("card_reset", 3'h0, crst);
    cyc(100);
    chk("card_reset", 3'h1, crst);
  endtask
  // Random line and side; the first side to fall is the input
  task automatic arb;
    int k, s;
    repeat (4) begin
      k = ($random(seed) & 32'h7fff) % 3;
      s = $random(seed) & 1;
      hp[k] = s;
      cp[k] = !s;
      cyc(8);
      chk("far_level", 3'h0, s ? cl[k] : hl[k]);
      {hp, cp} = 6'h0;
      cyc(8);
      chk("card_oe_n", 3'h7, coe);
      chk("host_oe_n", 3'h7, hoe);
    end
  endtask
  // Deactivation: 0 request, 1 over-current, 2 logic supply, 3 removal
  task automatic dea(input int f);
    case (f)
      0: an = 1'h1;
      1: oc = 1'h1;
      2: vd = 1'h1;
      default: pr = 1'h0;
    endcase
    cyc(8);
    chk("irq_n", f == 0, irq);
    chk("card_reset", 3'h1, crst);
    cyc(2000);
    chk("card_reset", 3'h0, crst);
    chk("card_oe_n", 3'h7, coe);
    cyc(2000);
    chk("card_clock", 3'h0, cclk);
    chk("card_oe_n", 3'h7, coe);
    cyc(2000);
    chk("card_lines", 3'h0, coe | co);
    chk("supply", 3'h1, csup);
    cyc(2000);
    chk("supply", 3'h0, csup);
    {an, oc, vd, pr} = 4'h9;
    cyc(4100 + STAB);
    chk("irq_n", 3'h1, irq);
  endtask
  // Main sequence
  initial begin
    cyc(12);
    chk("host_oe_n", 3'h7, hoe);
    chk("card_lines", 3'h0, coe | co);
    rn = 1'h1;
    cyc(20);
    an = 1'h0;
    cyc(10);
    chk("supply", 3'h0, csup);
    chk("irq_n", 3'h0, irq);
    an = 1'h1;
    cyc(40);
    chk("irq_n", 3'h1, irq);
    ot = 1'h1;
    cyc(10);
    chk("irq_n", 3'h1, irq);
    ot = 1'h0;
    for (i = 0; i < 4; i++) begin
      act(i[0]);
      if (i == 0)
        arb;
      dea(i);
    end
    {an, vc} = 2'h1;
    cyc(2020);
    chk("irq_n", 3'h0, irq);
    chk("supply", 3'h0, csup);
    {an, vc} = 2'h2;
    cyc(4100);
    pd = 1'h1;
    pr = 1'h0;
    cyc(10);
    chk("low_power", 3'h1, lp);
    chk("irq_n", 3'h0, irq);
    pr = 1'h1;
    an = 1'h0;
    cyc(10);
    chk("irq_n", 3'h1, irq);
    chk("supply", 3'h0, csup);
    an = 1'h1;
    pd = 1'h0;
    cyc(10);
    chk("irq_n", 3'h0, irq);
    cyc(STAB + 20);
    chk("irq_n", 3'h1, irq);
    end_of_test;
  end
endmodule
